// ==== rtl/cmblk_pkg.sv ====
package cmblk_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SAMPLE_HZ = 10_000;
    localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

    // ------------------------------------------------------------
    // lock geometry
    // ------------------------------------------------------------
    localparam int unsigned CODE_W = 4;
    localparam int unsigned TRIES_MAX = 3;
    localparam int unsigned TRIES_W = 2;
    localparam logic [CODE_W-1:0] CODE_RST = 4'h0;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 8'h0C;

    // ctrl fields
    localparam int unsigned CTRL_BYPASS_BIT = 0;
    localparam int unsigned CTRL_CLEAR_BIT = 1;

    // status fields
    localparam int unsigned STS_CODE_LSB = 0;
    localparam int unsigned STS_OPEN_BIT = 4;
    localparam int unsigned STS_LOCKOUT_BIT = 5;
    localparam int unsigned STS_TRIES_LSB = 8;

    // interrupt event bits
    localparam int unsigned EVT_W = 3;
    localparam int unsigned EVT_UNLOCK_BIT = 0;
    localparam int unsigned EVT_FAIL_BIT = 1;
    localparam int unsigned EVT_LOCKOUT_BIT = 2;
    localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

    typedef enum logic [2:0] {
        CMBLK_REG_CTRL,
        CMBLK_REG_STATUS,
        CMBLK_REG_IRQ_STS,
        CMBLK_REG_IRQ_MSK,
        CMBLK_REG_NONE
    } cmblk_reg_t;

endpackage

// ==== rtl/cmblk_tries_if.sv ====
`timescale 1ns/1ps
interface cmblk_tries_if #(
    parameter int unsigned CW = 2
);
    logic fail_evt;
    logic clear;
    logic [CW-1:0] count;
    logic lockout;

    modport owner (
        input fail_evt,
        input clear,
        output count,
        output lockout
    );
    modport user (
        output fail_evt,
        output clear,
        input count,
        input lockout
    );
endinterface

// ==== rtl/cmblk_tick.sv ====
`timescale 1ns/1ps
module cmblk_tick
    import cmblk_pkg::*;
#(
    parameter int unsigned DIV = SAMPLE_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sample enable
    output logic tick
);
    localparam int unsigned CNT_W = $clog2(DIV);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV - 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } cmblk_tick_t;

    cmblk_tick_t st_r;
    cmblk_tick_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == CNT_LAST) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule

// ==== rtl/cmblk_tries.sv ====
`timescale 1ns/1ps
module cmblk_tries
    import cmblk_pkg::*;
#(
    parameter int unsigned MAX = TRIES_MAX,
    parameter int unsigned CW = TRIES_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // attempt tracking
    cmblk_tries_if.owner tr
);
    localparam logic [CW-1:0] CNT_MAX = CW'(MAX);

    typedef struct packed {
        logic [CW-1:0] count;
        logic lockout;
    } cmblk_tries_t;

    cmblk_tries_t st_r;
    cmblk_tries_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (tr.clear) begin
            st_nxt.count = '0;
            st_nxt.lockout = 1'b0;
        end
        // a failure in the clearing cycle still counts
        if (tr.fail_evt && st_r.count != CNT_MAX) begin
            st_nxt.count = (tr.clear ? '0 : st_r.count) + CW'(1);
        end
        if (st_nxt.count == CNT_MAX) begin
            st_nxt.lockout = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tr.count = st_r.count;
    assign tr.lockout = st_r.lockout;
endmodule

// ==== rtl/cmblk_top.sv ====
// What this block does
// - set-mode high follows code; low keeps it
// - raising set-mode again replaces stored code
// - stored code always driven on outputs
// - enter with matching code opens lock
// - open only while enter stays high
// - three failures lock out code inputs
// - lockout status high normally, low locked
// - reset clears lockout and failure count
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
module cmblk_top
    import cmblk_pkg::*;
#(
    parameter int unsigned DIV = SAMPLE_CYCLES,
    parameter int unsigned MAX_TRIES = TRIES_MAX,
    parameter int unsigned CW = TRIES_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // lock pins
    input wire logic program_mode_pin,
    input wire logic [CODE_W-1:0] code_in_pins,
    input wire logic verify_request_pin,
    output logic [CODE_W-1:0] stored_code_outputs,
    output logic open_indicator_pin,
    output logic lockout_status_pin,
    // interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic open;
        logic enter_q;
        logic lockout_status;
        logic bypass;
        logic [EVT_W-1:0] irq_sts;
        logic [EVT_W-1:0] irq_msk;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cmblk_state_t;

    localparam cmblk_state_t ST_RST = '{
        code: CODE_RST,
        open: 1'b0,
        enter_q: 1'b0,
        lockout_status: 1'b1,
        bypass: 1'b0,
        irq_sts: EVT_RST,
        irq_msk: EVT_RST,
        irq: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000
    };

    cmblk_state_t st_r;
    cmblk_state_t st_nxt;

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    logic tick;
    logic fail_evt;
    logic clear_req;

    cmblk_tries_if #(.CW(CW)) tr ();

    cmblk_tick #(.DIV(DIV)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    cmblk_tries #(.MAX(MAX_TRIES), .CW(CW)) u_tries (
        .pclk(pclk),
        .presetn(presetn),
        .tr(tr)
    );

    assign tr.fail_evt = fail_evt;
    assign tr.clear = clear_req;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic cmblk_reg_t reg_of(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CTRL: reg_of = CMBLK_REG_CTRL;
            OFS_STATUS: reg_of = CMBLK_REG_STATUS;
            OFS_IRQ_STS: reg_of = CMBLK_REG_IRQ_STS;
            OFS_IRQ_MSK: reg_of = CMBLK_REG_IRQ_MSK;
            default: reg_of = CMBLK_REG_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic sample;
        logic rise;
        logic match;
        logic access_wr;
        logic unlock_evt;
        logic lockout_evt;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] w1c;
        logic [31:0] rd;
        cmblk_reg_t sel;

        sample = tick | st_r.bypass;
        rise = verify_request_pin & ~st_r.enter_q;
        match = (code_in_pins == st_r.code);
        access_wr = psel & penable & st_r.pready & pwrite;
        sel = reg_of(paddr);
        unlock_evt = 1'b0;
        lockout_evt = 1'b0;
        evt = EVT_RST;
        fail_evt = 1'b0;
        clear_req = 1'b0;
        w1c = EVT_RST;
        rd = 32'h0000_0000;
        st_nxt = st_r;

        // lock behaviour, on the sample enable
        if (sample) begin
            st_nxt.enter_q = verify_request_pin;
            if (program_mode_pin && !tr.lockout) begin
                st_nxt.code = code_in_pins;
            end
            if (!verify_request_pin) begin
                st_nxt.open = 1'b0;
            end else if (rise && !tr.lockout) begin
                if (match) begin
                    st_nxt.open = 1'b1;
                    unlock_evt = 1'b1;
                end else begin
                    fail_evt = 1'b1;
                end
            end
        end

        // lockout pin is the inverse of the tries block lockout, one cycle on
        st_nxt.lockout_status = ~tr.lockout;
        lockout_evt = tr.lockout & st_r.lockout_status;

        // register writes at the access edge
        if (access_wr) begin
            case (sel)
                CMBLK_REG_CTRL: begin
                    st_nxt.bypass = pwdata[CTRL_BYPASS_BIT];
                    clear_req = pwdata[CTRL_CLEAR_BIT];
                end
                CMBLK_REG_IRQ_STS: begin
                    w1c = pwdata[EVT_W-1:0];
                end
                CMBLK_REG_IRQ_MSK: begin
                    st_nxt.irq_msk = pwdata[EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // sticky events, a new event beats the clear
        evt[EVT_UNLOCK_BIT] = unlock_evt;
        evt[EVT_FAIL_BIT] = fail_evt;
        evt[EVT_LOCKOUT_BIT] = lockout_evt;
        st_nxt.irq_sts = (st_r.irq_sts & ~w1c) | evt;
        st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_msk);

        // read mux
        case (sel)
            CMBLK_REG_CTRL: begin
                rd[CTRL_BYPASS_BIT] = st_r.bypass;
            end
            CMBLK_REG_STATUS: begin
                rd[STS_CODE_LSB +: CODE_W] = st_r.code;
                rd[STS_OPEN_BIT] = st_r.open;
                rd[STS_LOCKOUT_BIT] = tr.lockout;
                rd[STS_TRIES_LSB +: CW] = tr.count;
            end
            CMBLK_REG_IRQ_STS: begin
                rd[EVT_W-1:0] = st_r.irq_sts;
            end
            CMBLK_REG_IRQ_MSK: begin
                rd[EVT_W-1:0] = st_r.irq_msk;
            end
            default: begin
            end
        endcase

        // one-wait-free apb answer: ready in the access cycle
        if (psel && !penable && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = (sel == CMBLK_REG_NONE);
            st_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
        end else begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign stored_code_outputs = st_r.code;
    assign open_indicator_pin = st_r.open;
    assign lockout_status_pin = st_r.lockout_status;
    assign irq = st_r.irq;
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
endmodule

// ==== tb/cmblk_top_monitor.sv ====
`timescale 1ns/1ps
module cmblk_top_monitor
    import cmblk_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // lock pins
    input wire logic program_mode_pin,
    input wire logic [CODE_W-1:0] code_in_pins,
    input wire logic verify_request_pin,
    input wire logic [CODE_W-1:0] stored_code_outputs,
    input wire logic open_indicator_pin,
    input wire logic lockout_status_pin
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence ans_s;
        pready ##1 !pready;
    endsequence

    a_ready_zero: assert property (setup_s |=> ans_s)
        else $error("ready not one cycle after setup");
    a_err_map: assert property (setup_s and paddr > OFS_IRQ_MSK |=> pslverr)
        else $error("unmapped address without error");
    a_code_load: assert property ($changed(stored_code_outputs) |->
        $past(program_mode_pin) && $past(lockout_status_pin)
        && stored_code_outputs == $past(code_in_pins))
        else $error("stored code changed without set mode");
    a_open_cause: assert property ($rose(open_indicator_pin) |->
        $past(verify_request_pin) && $past(lockout_status_pin)
        && $past(code_in_pins) == $past(stored_code_outputs))
        else $error("open without matching enter");
    a_open_drop: assert property ($fell(open_indicator_pin) |-> !$past(verify_request_pin))
        else $error("open dropped while enter high");
    a_lock_fall: assert property ($fell(lockout_status_pin) |->
        $past(verify_request_pin, 2))
        else $error("lockout without attempt");
    a_lock_no_open: assert property (!lockout_status_pin |-> !open_indicator_pin)
        else $error("open during lockout");
endmodule

bind cmblk_top cmblk_top_monitor i_cmblk_top_monitor (.pclk, .presetn, .psel, .penable,
    .paddr, .pready, .pslverr, .program_mode_pin, .code_in_pins, .verify_request_pin,
    .stored_code_outputs, .open_indicator_pin, .lockout_status_pin);

// ==== tb/cmblk_user_model.sv ====
`timescale 1ns/1ps
module cmblk_user_model
    import cmblk_pkg::*;
(
    // clock
    input wire logic pclk,
    // switches
    output logic program_mode_pin,
    output logic [CODE_W-1:0] code_in_pins,
    output logic verify_request_pin
);
    initial begin
        program_mode_pin = 1'b0;
        code_in_pins = 4'h0;
        verify_request_pin = 1'b0;
    end

    // set one switch pose, hold it n cycles
    task automatic pose(input logic m, input logic [CODE_W-1:0] c, input logic v,
        input int n);
        @(posedge pclk);
        program_mode_pin <= m;
        code_in_pins <= c;
        verify_request_pin <= v;
        repeat (n) @(posedge pclk);
    endtask
endmodule

// ==== tb/cmblk_top_tb.sv ====
`timescale 1ns/1ps
module cmblk_top_tb
    import cmblk_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic program_mode_pin, verify_request_pin, open_indicator_pin, lockout_status_pin;
    logic [CODE_W-1:0] code_in_pins, stored_code_outputs;
    int n_mismatch = 0;
    int total_checks = 0;

    cmblk_top #(.DIV(4)) i_cmblk_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .program_mode_pin, .code_in_pins,
        .verify_request_pin, .stored_code_outputs, .open_indicator_pin,
        .lockout_status_pin, .irq);
    cmblk_user_model i_cmblk_user_model (.pclk, .program_mode_pin, .code_in_pins,
        .verify_request_pin);

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the access edge settle before pins are compared
        @(posedge pclk);
    endtask

    task automatic pose(input logic m, input logic [CODE_W-1:0] c, input logic v);
        i_cmblk_user_model.pose(m, c, v, 4);
    endtask

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", s, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_STATUS, 0);
        chk("status", 32'h0, rd);
        chk("lockout", 1, lockout_status_pin);
        apb(1'b0, 8'h10, 0);
        chk("slverr", 1, err);
        apb(1'b1, OFS_CTRL, 1);
        apb(1'b1, OFS_IRQ_MSK, 7);
        pose(1'b1, 4'h5, 1'b0);
        pose(1'b0, 4'h5, 1'b0);
        chk("code", 5, stored_code_outputs);
        pose(1'b1, 4'hA, 1'b0);
        pose(1'b0, 4'h3, 1'b0);
        chk("code", 32'hA, stored_code_outputs);
        pose(1'b0, 4'hA, 1'b1);
        chk("open", 1, open_indicator_pin);
        chk("irq", 1, irq);
        pose(1'b0, 4'hA, 1'b0);
        chk("open", 0, open_indicator_pin);
        apb(1'b0, OFS_IRQ_STS, 0);
        chk("irq_sts", 1, rd);
        apb(1'b1, OFS_IRQ_STS, 1);
        chk("irq", 0, irq);
        for (int i = 0; i < 3; i++) begin
            pose(1'b0, 4'h3, 1'b1);
            pose(1'b0, 4'h3, 1'b0);
            apb(1'b0, OFS_STATUS, 0);
            chk("tries", i + 1, rd[9:8]);
            chk("lk_bit", i == 2, rd[STS_LOCKOUT_BIT]);
            chk("lockout", i < 2, lockout_status_pin);
        end
        pose(1'b0, 4'hA, 1'b1);
        chk("open", 0, open_indicator_pin);
        pose(1'b0, 4'hA, 1'b0);
        apb(1'b0, OFS_IRQ_STS, 0);
        chk("irq_sts", 6, rd);
        apb(1'b1, OFS_IRQ_MSK, 0);
        chk("irq", 0, irq);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_STATUS, 0);
        chk("status", 32'h0, rd);
        chk("lockout", 1, lockout_status_pin);
        // divided sample enable from here on, so poses last two periods
        i_cmblk_user_model.pose(1'b0, 4'h0, 1'b1, 8);
        chk("open", 1, open_indicator_pin);
        i_cmblk_user_model.pose(1'b0, 4'h3, 1'b0, 8);
        chk("open", 0, open_indicator_pin);
        i_cmblk_user_model.pose(1'b0, 4'h3, 1'b1, 8);
        apb(1'b0, OFS_STATUS, 0);
        chk("tries", 1, rd[9:8]);
        apb(1'b1, OFS_CTRL, 2);
        apb(1'b0, OFS_STATUS, 0);
        chk("tries", 0, rd[9:8]);
        report_and_stop();
    end
endmodule
